// ===== logic/spf_consts.svh
// Constants of the serial port, pattern test and receive fault enable block.
// Assumes an 8-bit microprocessor port and a single 250 MHz clock.
// Contract
// [RQ1] All-line select sends command and data bytes to all seven transceivers.
// [RQ2] Software writes zero to reserved bits 6, 3 and fault bit 4.
// [RQ3] Pattern test enable turns on generator and analyzer together.
// [RQ4] Channel field picks the decoder output fed to the analyzer, bit 0 LSB.
// [RQ5] Analyzer indications read zero when disabled or locked, else one; code gates event by pattern_event_mask and fail mask by pattern_alarm_enable.
// [RQ6] Invert generator output and/or analyzer input when invert bits are set; code asserts the invert outputs only while pattern enable bit 5 is set.
// [RQ7] Trigger bit set to one causes exactly one serial transfer.
// [RQ8] Software clears the trigger bit before requesting another transfer.
// [RQ9] Channel value N from 0 to 6 asserts chip select N+1, active low.
// [RQ10] All-line select asserts all seven chip selects together.
// [RQ11] Fault enable bit 7 lets a drop-bus clock failure drive the alarm.
// [RQ12] Fault enable bit 6 lets a drop-bus frame sync failure drive the alarm.
// [RQ13] Fault enable bit 5 lets a payload flag failure drive the alarm.
// [RQ14] Command byte shifts out first, least significant bit first.
// [RQ15] Output data byte shifts out second, least significant bit first.
// [RQ16] Read-back byte captured LSB first into the serial input data register.
// [RQ17] A transfer starts only on a zero-to-one change of the trigger bit.
// [RQ18] All enabled fault detectors combine into one alarm output.
`ifndef SPF_CONSTS_SVH
`define SPF_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPF_ADDR_CMD 9'h017
`define SPF_ADDR_DOUT 9'h018
`define SPF_ADDR_DIN 9'h019
`define SPF_ADDR_CTL 9'h01A
`define SPF_ADDR_FEN 9'h01B

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define SPF_CTL_ALL 7
`define SPF_CTL_PAT 5
`define SPF_CTL_TRIG 4
`define SPF_CTL_CH_HI 2
`define SPF_CTL_WMASK 8'hB7
`define SPF_FEN_CLK 7
`define SPF_FEN_SYNC 6
`define SPF_FEN_PAY 5
`define SPF_FEN_WMASK 8'hEF
`define SPF_BYTE_RST 8'h00
`define SPF_CS_IDLE 7'h7F
`define SPF_CS_ALL 7'h00
`define SPF_NUM_LINES 3'h7

// ----------------------------------------
// Serial timing
// ----------------------------------------
`define SPF_CLK_NS 4
`define SPF_SCLK_NS 32
`define SPF_HALF_CYC (`SPF_SCLK_NS / (2 * `SPF_CLK_NS))
`define SPF_OUT_BITS 5'h10
`define SPF_LAST_BIT 5'h17

`endif

// ===== logic/spf_pkg.sv
// Types of the serial port, pattern test and receive fault enable block.
// Assumes the constants header is included by users of these types.
package spf_pkg;

  // Serial transfer sequencer states
  typedef enum logic [1:0] {
    SPF_IDLE,
    SPF_SHIFT
  } spf_state_t;

  // Microprocessor port request
  typedef struct packed {
    logic [8:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } spf_cpu_req_t;

  // Fault detector reports
  typedef struct packed {
    logic clock_fail;
    logic sync_fail;
    logic payload_fail;
  } spf_fault_t;

  // Pattern analyzer indications
  typedef struct packed {
    logic pattern_status;
    logic pattern_event;
    logic pattern_persist_mask;
    logic pattern_fail_mask;
  } spf_pat_ind_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] dout;
    logic [7:0] din;
    logic [7:0] ctl;
    logic [7:0] fen;
    logic trig_prev;
    spf_state_t state;
    logic [4:0] bitcnt;
    logic [3:0] divcnt;
    logic [15:0] shift;
    logic [7:0] in_shift;
    logic sclk;
    logic sdo;
    logic [6:0] cs_n;
    logic alarm;
    logic [7:0] rdata;
    logic gen_en;
    logic ana_en;
    logic [2:0] ana_ch;
    logic gen_inv;
    logic ana_inv;
    spf_pat_ind_t ind;
    logic busy;
  } spf_regs_t;

endpackage : spf_pkg

// ===== logic/spf_top.sv
// Control registers, serial line-interface port, pattern test control
// and receive fault alarm gating of the seven-channel line mapper.
// Assumes all inputs are synchronous to clk and the microprocessor
// port presents one-cycle read and write strobes.
`timescale 1ns/10ps
`include "spf_consts.svh"

module spf_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Microprocessor port
  input spf_pkg::spf_cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  // Transceiver serial port
  output logic line_serial_clk,
  output logic line_serial_out,
  input wire logic line_serial_in,
  output logic [6:0] line_chip_selects_n,
  output logic serial_busy,
  // Pattern generator and analyzer
  input wire logic tx_pattern_invert,
  input wire logic rx_pattern_invert,
  input wire logic pattern_event_mask,
  input wire logic pattern_alarm_enable,
  input wire logic analyzer_locked,
  output logic pattern_gen_enable,
  output logic pattern_ana_enable,
  output logic [2:0] pattern_ana_channel,
  output logic pattern_gen_invert,
  output logic pattern_ana_invert,
  output spf_pkg::spf_pat_ind_t pattern_ind,
  // Drop-bus fault detectors and alarm
  input spf_pkg::spf_fault_t rx_faults,
  output logic alarm_out
);
  import spf_pkg::*;

  spf_regs_t s_r;
  spf_regs_t s_nxt;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Chip select pattern for a channel; value 7 selects nothing
  function automatic logic [6:0] cs_decode(input logic all, input logic [2:0] ch);
    logic [6:0] v;
    v = `SPF_CS_IDLE;
    if (all) begin
      v = `SPF_CS_ALL; // RQ10 RQ1
    end else if (ch < `SPF_NUM_LINES) begin
      v[ch] = 1'b0; // RQ9
    end
    return v;
  endfunction : cs_decode

  // Keep reserved bits at zero whatever software writes
  function automatic logic [7:0] wmask(input logic [7:0] d, input logic [7:0] m);
    return d & m;
  endfunction : wmask

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------

  // One process computes the whole next state
  always_comb begin
    logic trig_rise;
    logic half_done;
    trig_rise = 1'b0;
    half_done = 1'b0;
    s_nxt = s_r;

    // Register writes; reserved bits dropped since software may slip
    if (cpu_req.wr) begin
      case (cpu_req.addr)
        `SPF_ADDR_CMD: begin
          s_nxt.cmd = cpu_req.wdata;
        end
        `SPF_ADDR_DOUT: begin
          s_nxt.dout = cpu_req.wdata;
        end
        `SPF_ADDR_CTL: begin
          s_nxt.ctl = wmask(cpu_req.wdata, `SPF_CTL_WMASK); // RQ2
        end
        `SPF_ADDR_FEN: begin
          s_nxt.fen = wmask(cpu_req.wdata, `SPF_FEN_WMASK); // RQ2
        end
        default: begin
        end
      endcase
    end

    // Register reads, unmapped addresses answer zero
    if (cpu_req.rd) begin
      case (cpu_req.addr)
        `SPF_ADDR_CMD: begin
          s_nxt.rdata = s_r.cmd;
        end
        `SPF_ADDR_DOUT: begin
          s_nxt.rdata = s_r.dout;
        end
        `SPF_ADDR_DIN: begin
          s_nxt.rdata = s_r.din;
        end
        `SPF_ADDR_CTL: begin
          s_nxt.rdata = s_r.ctl;
        end
        `SPF_ADDR_FEN: begin
          s_nxt.rdata = s_r.fen;
        end
        default: begin
          s_nxt.rdata = `SPF_BYTE_RST;
        end
      endcase
    end

    // Edge detect on the trigger bit; a level held at one starts nothing
    s_nxt.trig_prev = s_r.ctl[`SPF_CTL_TRIG];
    trig_rise = s_r.ctl[`SPF_CTL_TRIG] & ~s_r.trig_prev; // RQ17 RQ7 RQ8

    // Serial sequencer: 16 bits out, then 8 bits read back
    half_done = (s_r.divcnt == 4'(`SPF_HALF_CYC - 1));
    case (s_r.state)
      SPF_IDLE: begin
        s_nxt.sclk = 1'b0;
        if (trig_rise) begin
          s_nxt.state = SPF_SHIFT; // RQ7
          s_nxt.busy = 1'b1;
          s_nxt.cs_n = cs_decode(s_r.ctl[`SPF_CTL_ALL],
                                 s_r.ctl[`SPF_CTL_CH_HI:0]); // RQ9 RQ10 RQ1
          s_nxt.shift = {s_r.dout, s_r.cmd}; // RQ14 RQ15
          s_nxt.sdo = s_r.cmd[0]; // RQ14
          s_nxt.bitcnt = 5'h00;
          s_nxt.divcnt = 4'h0;
          s_nxt.in_shift = `SPF_BYTE_RST;
        end
      end
      SPF_SHIFT: begin
        s_nxt.divcnt = half_done ? 4'h0 : s_r.divcnt + 4'h1;
        if (half_done) begin
          s_nxt.sclk = ~s_r.sclk;
          if (!s_r.sclk) begin
            // Rising edge: the transceiver's bit is stable here
            if (s_r.bitcnt >= `SPF_OUT_BITS) begin
              s_nxt.in_shift = {line_serial_in, s_r.in_shift[7:1]}; // RQ16
            end
          end else if (s_r.bitcnt == `SPF_LAST_BIT) begin
            // Falling edge after the last bit closes the transfer
            s_nxt.state = SPF_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.cs_n = `SPF_CS_IDLE;
            s_nxt.sdo = 1'b0;
            s_nxt.din = s_r.in_shift; // RQ16
          end else begin
            // Falling edge: advance to the next output bit
            s_nxt.bitcnt = s_r.bitcnt + 5'h01;
            s_nxt.shift = {1'b0, s_r.shift[15:1]}; // RQ14 RQ15
            s_nxt.sdo = s_r.shift[1];
          end
        end
      end
      default: begin
        s_nxt.state = SPF_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.cs_n = `SPF_CS_IDLE;
      end
    endcase

    // Pattern test controls follow the control register
    s_nxt.gen_en = s_r.ctl[`SPF_CTL_PAT]; // RQ3
    s_nxt.ana_en = s_r.ctl[`SPF_CTL_PAT]; // RQ3
    s_nxt.ana_ch = s_r.ctl[`SPF_CTL_CH_HI:0]; // RQ4
    s_nxt.gen_inv = s_r.ctl[`SPF_CTL_PAT] & tx_pattern_invert; // RQ6
    s_nxt.ana_inv = s_r.ctl[`SPF_CTL_PAT] & rx_pattern_invert; // RQ6

    // Indications are zero when disabled or locked, else one; event and fail mask also gated by inputs
    s_nxt.ind.pattern_status = s_r.ana_en & ~analyzer_locked; // RQ5
    s_nxt.ind.pattern_event = s_r.ana_en & ~analyzer_locked
                              & ~pattern_event_mask; // RQ5
    s_nxt.ind.pattern_persist_mask = s_r.ana_en & ~analyzer_locked; // RQ5
    s_nxt.ind.pattern_fail_mask = s_r.ana_en & ~analyzer_locked
                                  & pattern_alarm_enable; // RQ5

    // Alarm is the OR of every enabled drop-bus fault detector
    s_nxt.alarm = (s_r.fen[`SPF_FEN_CLK] & rx_faults.clock_fail) // RQ11 RQ18
                | (s_r.fen[`SPF_FEN_SYNC] & rx_faults.sync_fail) // RQ12
                | (s_r.fen[`SPF_FEN_PAY] & rx_faults.payload_fail); // RQ13
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // Synchronous reset puts every field at a quiet value
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.state <= SPF_IDLE;
      s_r.cs_n <= `SPF_CS_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------
  assign cpu_rdata = s_r.rdata;
  assign line_serial_clk = s_r.sclk;
  assign line_serial_out = s_r.sdo;
  assign line_chip_selects_n = s_r.cs_n;
  assign serial_busy = s_r.busy;
  assign pattern_gen_enable = s_r.gen_en;
  assign pattern_ana_enable = s_r.ana_en;
  assign pattern_ana_channel = s_r.ana_ch;
  assign pattern_gen_invert = s_r.gen_inv;
  assign pattern_ana_invert = s_r.ana_inv;
  assign pattern_ind = s_r.ind;
  assign alarm_out = s_r.alarm;

endmodule : spf_top

// ===== test/spf_properties.sv
// Checker of register, serial start and alarm timing of spf_top.
// Assumes binding to spf_top; shadows the two control registers.
`timescale 1ns/10ps
`include "spf_consts.svh"
module spf_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input spf_pkg::spf_cpu_req_t cpu_req,
  input wire logic [6:0] line_chip_selects_n,
  input wire logic serial_busy,
  input wire logic tx_pattern_invert,
  input wire logic pattern_event_mask,
  input wire logic pattern_alarm_enable,
  input wire logic analyzer_locked,
  input wire logic pattern_gen_enable,
  input wire logic pattern_ana_enable,
  input wire logic [2:0] pattern_ana_channel,
  input wire logic pattern_gen_invert,
  input spf_pkg::spf_pat_ind_t pattern_ind,
  input spf_pkg::spf_fault_t rx_faults,
  input wire logic alarm_out
);
  import spf_pkg::*;
  logic [7:0] ctl_s;
  logic [7:0] fen_s;
  // Indications trail the enable outputs by one more register stage
  logic pat_d;
  wire logic e = pat_d && !analyzer_locked;
  // Shadows follow writes with the reserved bits masked
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_s <= 8'h00;
      fen_s <= 8'h00;
      pat_d <= 1'b0;
    end else begin
      pat_d <= ctl_s[5];
      if (cpu_req.wr) begin
        if (cpu_req.addr == `SPF_ADDR_CTL) ctl_s <= cpu_req.wdata & `SPF_CTL_WMASK;
        if (cpu_req.addr == `SPF_ADDR_FEN) fen_s <= cpu_req.wdata & `SPF_FEN_WMASK;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence trig_rise_s; ctl_s[4] && !$past(ctl_s[4]) && !serial_busy; endsequence
  sequence start_s; $rose(serial_busy); endsequence
  pat_enable_a: assert property (pattern_gen_enable == $past(ctl_s[5]) &&
    pattern_ana_enable == $past(ctl_s[5])) else $error("pattern enable mismatch");
  pat_channel_a: assert property (pattern_ana_channel == $past(ctl_s[2:0]))
    else $error("analyzer channel mismatch");
  pat_ind_a: assert property (pattern_ind == $past({e, e && !pattern_event_mask, e,
    e && pattern_alarm_enable})) else $error("indication mismatch");
  pat_invert_a: assert property (pattern_gen_invert ==
    $past(ctl_s[5] && tx_pattern_invert)) else $error("generator invert mismatch");
  alarm_gate_a: assert property (alarm_out == $past(|(fen_s[7:5] & rx_faults)))
    else $error("alarm mismatch");
  cs_bcast_a: assert property (start_s ##0 ctl_s[7] |-> line_chip_selects_n == 7'h00)
    else $error("broadcast select wrong");
  cs_single_a: assert property (start_s ##0 !ctl_s[7] |->
    line_chip_selects_n == ~(7'h01 << ctl_s[2:0])) else $error("single select wrong");
  trig_start_a: assert property (trig_rise_s |=> serial_busy)
    else $error("transfer did not start");
  trig_held_a: assert property (ctl_s[4] && $past(ctl_s[4]) && !serial_busy |=>
    !serial_busy) else $error("held trigger started a transfer");
  cs_hold_a: assert property (serial_busy && $past(serial_busy) |->
    $stable(line_chip_selects_n)) else $error("chip selects moved in transfer");
endmodule : spf_properties
bind spf_top spf_properties chk_u (.clk(clk), .reset(reset), .cpu_req(cpu_req),
  .line_chip_selects_n(line_chip_selects_n), .serial_busy(serial_busy),
  .tx_pattern_invert(tx_pattern_invert), .pattern_event_mask(pattern_event_mask),
  .pattern_alarm_enable(pattern_alarm_enable), .analyzer_locked(analyzer_locked),
  .pattern_gen_enable(pattern_gen_enable), .pattern_ana_enable(pattern_ana_enable),
  .pattern_ana_channel(pattern_ana_channel), .pattern_gen_invert(pattern_gen_invert),
  .pattern_ind(pattern_ind), .rx_faults(rx_faults), .alarm_out(alarm_out));

// ===== test/spf_xcvr_model.sv
// Behavioural model of the seven line transceivers on the serial port.
// Assumes a serial clock registered from clk that idles low.
`timescale 1ns/10ps
module spf_xcvr_model (
  // Clock
  input wire logic clk,
  // Serial port
  input wire logic line_serial_clk,
  input wire logic line_serial_out,
  input wire logic [6:0] line_chip_selects_n,
  output logic line_serial_in,
  // Bench side
  input wire logic [7:0] rb_byte,
  output logic [15:0] got_bits,
  output logic [6:0] cs_seen
);
  logic ps = 1'b0;
  logic [4:0] cnt = 5'h00;
  initial line_serial_in = 1'b0;
  // Count rising edges; out bits in, read-back out after falling edges
  always @(posedge clk) begin
    ps <= line_serial_clk;
    if (&line_chip_selects_n) begin
      cnt <= 5'h00;
      line_serial_in <= ~line_serial_in; // Released line never shows a stale bit
    end else begin
      cs_seen <= line_chip_selects_n;
      if (line_serial_clk && !ps) begin
        cnt <= cnt + 5'h01;
        if (cnt < 5'h10) got_bits <= {line_serial_out, got_bits[15:1]};
      end
      if (cnt < 5'h10) line_serial_in <= ~line_serial_in;
      else if (!line_serial_clk && ps && cnt < 5'h18) line_serial_in <= rb_byte[cnt[2:0]];
    end
  end
endmodule : spf_xcvr_model

// ===== test/test_spf_top.sv
// Self-checking bench of spf_top with the transceiver model.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
`include "spf_consts.svh"
module test_spf_top;
  import spf_pkg::*;
  logic clk = 1'b0, reset = 1'b1, tx_inv = 1'b0, rx_inv = 1'b0, ev_mask = 1'b0;
  logic al_en = 1'b0, locked = 1'b0, sclk, sdo, sdi, busy, gen_en, ana_en, gen_inv, ana_inv;
  logic alarm, e;
  logic [6:0] cs_n, cs_seen;
  logic [2:0] ana_ch;
  logic [7:0] cpu_rdata, c, kb, rb = 8'h00;
  logic [15:0] got_bits;
  spf_cpu_req_t cpu_req = '0;
  spf_pat_ind_t ind;
  spf_fault_t faults = '0;
  int n_fail = 0, n_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  spf_top dut_u (.clk(clk), .reset(reset), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .line_serial_clk(sclk), .line_serial_out(sdo), .line_serial_in(sdi),
    .line_chip_selects_n(cs_n), .serial_busy(busy), .tx_pattern_invert(tx_inv),
    .rx_pattern_invert(rx_inv), .pattern_event_mask(ev_mask), .pattern_alarm_enable(al_en),
    .analyzer_locked(locked), .pattern_gen_enable(gen_en), .pattern_ana_enable(ana_en),
    .pattern_ana_channel(ana_ch), .pattern_gen_invert(gen_inv), .pattern_ana_invert(ana_inv),
    .pattern_ind(ind), .rx_faults(faults), .alarm_out(alarm));
  spf_xcvr_model model_u (.clk(clk), .line_serial_clk(sclk), .line_serial_out(sdo),
    .line_chip_selects_n(cs_n), .line_serial_in(sdi), .rb_byte(rb), .got_bits(got_bits),
    .cs_seen(cs_seen));
  task results();
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Outputs are read at the falling edge, after registered updates land
  task settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    cpu_req.addr <= a;
    cpu_req.wdata <= d;
    cpu_req.wr <= 1'b1;
    @(posedge clk);
    cpu_req.wr <= 1'b0;
  endtask : wr
  task rd_chk(input string nm, input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk);
    cpu_req.addr <= a;
    cpu_req.rd <= 1'b1;
    @(posedge clk);
    cpu_req.rd <= 1'b0;
    settle(1);
    chk(nm, cpu_rdata, exp);
  endtask : rd_chk
  task wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) chk("busy wait", 1'b0, 1'b1);
  endtask : wait_busy
  // Hang guard, well above the few thousand cycles of the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd_chk("ctl reset", `SPF_ADDR_CTL, 8'h00);
    rd_chk("fen reset", `SPF_ADDR_FEN, 8'h00);
    wr(`SPF_ADDR_CTL, 8'hEF);
    rd_chk("ctl reserved", `SPF_ADDR_CTL, 8'hA7);
    wr(`SPF_ADDR_FEN, 8'hFF);
    rd_chk("fen reserved", `SPF_ADDR_FEN, 8'hEF);
    rd_chk("unmapped", 9'h1FF, 8'h00);
    // Pattern enable, channel, inversion and indications over all inputs
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      {locked, ev_mask, al_en, tx_inv} <= i[3:0];
      rx_inv <= ~i[0];
      wr(`SPF_ADDR_CTL, {2'b00, i[4], 2'b00, i[2:0]});
      settle(2);
      e = i[4] & ~i[3];
      chk("pattern enable", {gen_en, ana_en}, {2{i[4]}});
      chk("channel", ana_ch, i[2:0]);
      chk("invert", {gen_inv, ana_inv}, {i[4] & i[0], i[4] & ~i[0]});
      chk("indications", ind, {e, e & ~i[2], e, e & i[1]});
    end
    // Every enable mask against every fault combination
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      faults <= i[2:0];
      wr(`SPF_ADDR_FEN, {i[5:3], 5'h00});
      settle(2);
      chk("alarm", alarm, |(i[5:3] & i[2:0]));
    end
    // Channels 0 to 6, then broadcast; trigger held high must not restart
    for (int k = 0; k < 8; k++) begin
      kb = k[7:0];
      c = (k < 7) ? kb : 8'h80;
      rb = 8'h5A ^ kb;
      wr(`SPF_ADDR_CMD, 8'hA0 | kb);
      wr(`SPF_ADDR_DOUT, 8'h3C ^ kb);
      wr(`SPF_ADDR_CTL, c);
      wr(`SPF_ADDR_CTL, c | 8'h10);
      wait_busy(1'b1);
      wait_busy(1'b0);
      chk("selects", cs_seen, (k < 7) ? 7'(~(7'h01 << k)) : 7'h00);
      chk("bytes", got_bits, {8'h3C ^ kb, 8'hA0 | kb});
      rd_chk("read back", `SPF_ADDR_DIN, 8'h5A ^ kb);
      wr(`SPF_ADDR_CTL, c | 8'h10);
      settle(20);
      chk("held trigger", busy, 1'b0);
    end
    results();
  end
endmodule : test_spf_top
